/* src/iowfd_regs.svh */
// Offsets, field positions and reset values of the I/O window decoder
`ifndef IOWFD_REGS_SVH
`define IOWFD_REGS_SVH

// Configuration byte offsets
`define IOWFD_BASE_LOW_OFF 8'h1C
`define IOWFD_LIMIT_LOW_OFF 8'h1D
`define IOWFD_BASE_HIGH_OFF 8'h30
`define IOWFD_LIMIT_HIGH_OFF 8'h32

// Read-only low nibble of the 8-bit fields: 32-bit I/O addressing
`define IOWFD_ADDR32_CAP 4'h1

// Reset values of the writable fields (base 0000_0000h, limit 0000_0FFFh)
`define IOWFD_BASE_LOW_RST 4'h0
`define IOWFD_LIMIT_LOW_RST 4'h0
`define IOWFD_BASE_HIGH_RST 16'h0000
`define IOWFD_LIMIT_HIGH_RST 16'h0000

// Implied low twelve address bits of the window ends
`define IOWFD_BASE_FILL 12'h000
`define IOWFD_LIMIT_FILL 12'hFFF

// Legacy ISA filter: first 64 KB, top 768 bytes of each 1 KB block
`define IOWFD_ISA_REGION_HI 16'h0000
`define IOWFD_ISA_LOW_QUARTER 2'h0
`define IOWFD_ISA_BLK_MSB 9
`define IOWFD_ISA_BLK_LSB 8

`endif

/* src/iowfd_pkg.sv */
// Types shared by the I/O window decoder files
package iowfd_pkg;

  // Configuration access from the configuration space logic
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } iowfd_cfg_req_t;

  // Read answer
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } iowfd_cfg_rsp_t;

  // One I/O transaction seen on a bus
  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } iowfd_txn_t;

  // Full 32-bit window ends
  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit;
  } iowfd_win_t;

  // Writable window fields
  typedef struct packed {
    logic [3:0] base_low;
    logic [3:0] limit_low;
    logic [15:0] base_high;
    logic [15:0] limit_high;
  } iowfd_fields_t;

  // Register file state
  typedef struct packed {
    iowfd_fields_t f;
    iowfd_cfg_rsp_t rsp;
  } iowfd_cfg_state_t;

  // Forwarding decisions handed out
  typedef struct packed {
    logic down_fwd;
    logic [31:0] down_addr;
    logic up_fwd;
    logic [31:0] up_addr;
    logic pri_isa_refused;
    logic sec_ignored;
  } iowfd_fwd_state_t;

endpackage : iowfd_pkg

/* src/iowfd_cfg_regs.sv */
// Window base and limit registers with their configuration read port
`timescale 1ns/1ns
`include "iowfd_regs.svh"

module iowfd_cfg_regs
  import iowfd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input iowfd_cfg_req_t cfg_req,
  output iowfd_cfg_rsp_t cfg_rsp,
  output iowfd_win_t win
);

  iowfd_cfg_state_t st;
  iowfd_cfg_state_t next_st;

  // Dword match of an access against a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  // Byte lane enable of a register's byte within the dword
  function automatic logic lane(input logic [3:0] be, input logic [7:0] off);
    lane = be[off[1:0]];
  endfunction : lane

  // Writes by byte lane, reads answered one cycle later
  always_comb begin
    next_st = st;
    next_st.rsp.valid = 1'b0;
    if (cfg_req.wr) begin
      if (hit(cfg_req.addr, `IOWFD_BASE_LOW_OFF) && lane(cfg_req.be, `IOWFD_BASE_LOW_OFF)) begin
        next_st.f.base_low = cfg_req.wdata[7:4];
      end
      if (hit(cfg_req.addr, `IOWFD_LIMIT_LOW_OFF) && lane(cfg_req.be, `IOWFD_LIMIT_LOW_OFF)) begin
        next_st.f.limit_low = cfg_req.wdata[15:12];
      end
      if (hit(cfg_req.addr, `IOWFD_BASE_HIGH_OFF)) begin
        if (cfg_req.be[0]) begin
          next_st.f.base_high[7:0] = cfg_req.wdata[7:0];
        end
        if (cfg_req.be[1]) begin
          next_st.f.base_high[15:8] = cfg_req.wdata[15:8];
        end
      end
      if (hit(cfg_req.addr, `IOWFD_LIMIT_HIGH_OFF)) begin
        if (cfg_req.be[2]) begin
          next_st.f.limit_high[7:0] = cfg_req.wdata[23:16];
        end
        if (cfg_req.be[3]) begin
          next_st.f.limit_high[15:8] = cfg_req.wdata[31:24];
        end
      end
    end
    if (cfg_req.rd) begin
      next_st.rsp.valid = 1'b1;
      next_st.rsp.data = 32'h0000_0000;
      if (hit(cfg_req.addr, `IOWFD_BASE_LOW_OFF)) begin
        next_st.rsp.data[7:0] = {st.f.base_low, `IOWFD_ADDR32_CAP};
        next_st.rsp.data[15:8] = {st.f.limit_low, `IOWFD_ADDR32_CAP};
      end
      if (hit(cfg_req.addr, `IOWFD_BASE_HIGH_OFF)) begin
        next_st.rsp.data = {st.f.limit_high, st.f.base_high};
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st.f.base_low <= `IOWFD_BASE_LOW_RST;
      st.f.limit_low <= `IOWFD_LIMIT_LOW_RST;
      st.f.base_high <= `IOWFD_BASE_HIGH_RST;
      st.f.limit_high <= `IOWFD_LIMIT_HIGH_RST;
      st.rsp <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Full window ends with implied low bits
  assign win.base = {st.f.base_high, st.f.base_low, `IOWFD_BASE_FILL};
  assign win.limit = {st.f.limit_high, st.f.limit_low, `IOWFD_LIMIT_FILL};
  assign cfg_rsp = st.rsp;

endmodule : iowfd_cfg_regs

/* src/iowfd_window_cmp.sv */
// Window and legacy ISA address match for one address
`timescale 1ns/1ns
`include "iowfd_regs.svh"

module iowfd_window_cmp
  import iowfd_pkg::*;
(
  input iowfd_win_t win,
  input wire logic isa_enable,
  input wire logic [31:0] addr,
  output logic down_sel,
  output logic isa_refused
);

  logic in_win;
  logic low_64k;
  logic top_768;

  // Inclusive compare; base above limit never matches
  assign in_win = (addr >= win.base) && (addr <= win.limit);
  assign low_64k = (addr[31:16] == `IOWFD_ISA_REGION_HI);
  assign top_768 = (addr[`IOWFD_ISA_BLK_MSB:`IOWFD_ISA_BLK_LSB] != `IOWFD_ISA_LOW_QUARTER);

  // ISA filter only inside the window and below 64 KB
  assign isa_refused = isa_enable && in_win && low_64k && top_768;
  assign down_sel = in_win && !isa_refused;

endmodule : iowfd_window_cmp

/* src/iowfd_decoder.sv */
// I/O forwarding decoder of a two-bus bridge
`timescale 1ns/1ns
`include "iowfd_regs.svh"

// Summary of operation
// - Upstream I/O in window goes down; downstream I/O outside window goes up.
// - With I/O enable clear, upstream I/O is ignored.
// - With master enable clear, downstream I/O is ignored.
// - Base above limit disables the window; all downstream I/O goes up.
// - Window has 4 KB granularity; base low bits 000h, limit low bits FFFh.
// - Base-low upper nibble holds base bits 15:12; lower nibble reads 1h.
// - Base-high holds base bits 31:16, fully writable.
// - Limit-low nibble gives bits 15:12, reads 1h low; limit-high gives 31:16.
// - Reset gives window 0000_0000h to 0000_0FFFh.
// - ISA enable matters only in window and below 64 KB.
// - ISA mode forwards down only the bottom 256 bytes per 1 KB block below 64 KB.
// - ISA mode sends top 768 bytes per 1 KB below 64 KB upstream.
// - Above 64 KB, plain window decoding regardless of ISA enable.
// - Addresses pass untranslated; whatever is not sent down may go up.
module iowfd_decoder
  import iowfd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input iowfd_cfg_req_t cfg_req,
  output iowfd_cfg_rsp_t cfg_rsp,
  input wire logic io_enable,
  input wire logic master_enable,
  input wire logic isa_enable,
  input iowfd_txn_t pri_txn,
  input iowfd_txn_t sec_txn,
  output logic down_fwd,
  output logic [31:0] down_addr,
  output logic up_fwd,
  output logic [31:0] up_addr,
  output logic pri_isa_refused,
  output logic sec_ignored
);

  iowfd_win_t win;
  iowfd_fwd_state_t st;
  iowfd_fwd_state_t next_st;
  logic [1:0] sel;
  logic [1:0] refused;
  logic [31:0] addrs [2];

  // Register file for the window
  iowfd_cfg_regs u_regs (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp),
    .win(win)
  );

  // One comparator per bus: index 0 primary, 1 secondary
  assign addrs[0] = pri_txn.addr;
  assign addrs[1] = sec_txn.addr;

  for (genvar i = 0; i < 2; i++) begin : g_cmp
    iowfd_window_cmp u_cmp (
      .win(win),
      .isa_enable(isa_enable),
      .addr(addrs[i]),
      .down_sel(sel[i]),
      .isa_refused(refused[i])
    );
  end

  // Forwarding decisions; software keeps config steady while busy
  always_comb begin
    next_st = st;
    next_st.down_fwd = 1'b0;
    next_st.up_fwd = 1'b0;
    next_st.pri_isa_refused = 1'b0;
    next_st.sec_ignored = 1'b0;
    if (pri_txn.req && io_enable) begin
      if (sel[0]) begin
        next_st.down_fwd = 1'b1;
        next_st.down_addr = pri_txn.addr;
      end
      next_st.pri_isa_refused = refused[0];
    end
    if (sec_txn.req) begin
      if (!master_enable) begin
        next_st.sec_ignored = 1'b1;
      end else if (!sel[1]) begin
        next_st.up_fwd = 1'b1;
        next_st.up_addr = sec_txn.addr;
      end
    end
  end

  // Decision register, frozen while the clock enable is low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Outputs straight from the decision register
  assign down_fwd = st.down_fwd;
  assign down_addr = st.down_addr;
  assign up_fwd = st.up_fwd;
  assign up_addr = st.up_addr;
  assign pri_isa_refused = st.pri_isa_refused;
  assign sec_ignored = st.sec_ignored;

endmodule : iowfd_decoder

/* tb/iowfd_decoder_checker.sv */
// Port assertions of the I/O window decoder
`timescale 1ns/1ns
module iowfd_decoder_checker
  import iowfd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input iowfd_cfg_req_t cfg_req,
  input iowfd_cfg_rsp_t cfg_rsp,
  input wire logic io_enable,
  input wire logic master_enable,
  input wire logic isa_enable,
  input iowfd_txn_t pri_txn,
  input iowfd_txn_t sec_txn,
  input wire logic down_fwd,
  input wire logic [31:0] down_addr,
  input wire logic up_fwd,
  input wire logic [31:0] up_addr,
  input wire logic pri_isa_refused,
  input wire logic sec_ignored
);
  // One clock domain, frozen cycles skipped
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn || !clk_en);

  // Forwarding decisions against their causes, and the read answer one cycle after a read
  a_down_io_gate: assert property (down_fwd |-> $past(pri_txn.req && io_enable))
    else $error("downstream forward without enabled primary request");
  a_down_addr_same: assert property (down_fwd |-> down_addr == $past(pri_txn.addr))
    else $error("downstream address altered");
  a_up_master_gate: assert property (up_fwd |-> $past(sec_txn.req && master_enable))
    else $error("upstream forward without enabled secondary request");
  a_up_addr_same: assert property (up_fwd |-> up_addr == $past(sec_txn.addr))
    else $error("upstream address altered");
  a_sec_ignored: assert property (sec_txn.req && !master_enable |=> sec_ignored && !up_fwd)
    else $error("secondary request not ignored");
  a_isa_refuse_cause: assert property (pri_isa_refused |-> !down_fwd && $past(isa_enable &&
    pri_txn.addr[31:16] == 16'h0000 && pri_txn.addr[9:8] != 2'h0))
    else $error("legacy refusal without legacy address");
  a_high_plain: assert property (pri_txn.req && pri_txn.addr[31:16] != 16'h0000
    |=> !pri_isa_refused)
    else $error("legacy filter above 64 KB");
  a_rd_answer: assert property (cfg_req.rd |=> cfg_rsp.valid)
    else $error("read answer missing");
endmodule : iowfd_decoder_checker

bind iowfd_decoder iowfd_decoder_checker u_iowfd_decoder_checker (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .clk_en(clk_en),
  .cfg_req(cfg_req),
  .cfg_rsp(cfg_rsp),
  .io_enable(io_enable),
  .master_enable(master_enable),
  .isa_enable(isa_enable),
  .pri_txn(pri_txn),
  .sec_txn(sec_txn),
  .down_fwd(down_fwd),
  .down_addr(down_addr),
  .up_fwd(up_fwd),
  .up_addr(up_addr),
  .pri_isa_refused(pri_isa_refused),
  .sec_ignored(sec_ignored)
);

/* tb/iowfd_bus_model.sv */
// Initiators on the primary and secondary buses
`timescale 1ns/1ns
module iowfd_bus_model
  import iowfd_pkg::*;
(
  input wire logic ref_clk,
  output iowfd_txn_t pri_txn,
  output iowfd_txn_t sec_txn
);
  // Buses idle at start
  initial begin
    pri_txn = '0;
    sec_txn = '0;
  end

  // One-cycle request; released address shows its inverse
  task automatic issue(input logic sec, input logic [31:0] a);
    @(posedge ref_clk);
    if (sec) sec_txn <= '{1'b1, a};
    else pri_txn <= '{1'b1, a};
    @(posedge ref_clk);
    if (sec) sec_txn <= '{1'b0, ~a};
    else pri_txn <= '{1'b0, ~a};
  endtask : issue
endmodule : iowfd_bus_model

/* tb/iowfd_decoder_tb.sv */
// Self-checking bench of the I/O window decoder
`timescale 1ns/1ns
module iowfd_decoder_tb
  import iowfd_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic io_enable = 1'b0;
  logic master_enable = 1'b0;
  logic isa_enable = 1'b0;
  iowfd_cfg_req_t cfg_req = '0;
  iowfd_cfg_rsp_t cfg_rsp;
  iowfd_txn_t pri_txn, sec_txn;
  logic down_fwd, up_fwd, pri_isa_refused, sec_ignored;
  logic [31:0] down_addr, up_addr;
  int miscompares = 0;
  int total_checks = 0;

  // Clock and instances
  always #5 ref_clk = ~ref_clk;
  iowfd_bus_model u_iowfd_bus_model (
    .ref_clk(ref_clk),
    .pri_txn(pri_txn),
    .sec_txn(sec_txn)
  );
  iowfd_decoder u_iowfd_decoder (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp),
    .io_enable(io_enable),
    .master_enable(master_enable),
    .isa_enable(isa_enable),
    .pri_txn(pri_txn),
    .sec_txn(sec_txn),
    .down_fwd(down_fwd),
    .down_addr(down_addr),
    .up_fwd(up_fwd),
    .up_addr(up_addr),
    .pri_isa_refused(pri_isa_refused),
    .sec_ignored(sec_ignored)
  );

  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Config write and read
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge ref_clk);
    cfg_req <= '{1'b1, 1'b0, a, be, d};
    @(posedge ref_clk);
    cfg_req.wr <= 1'b0;
  endtask : cfg_wr
  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    cfg_req <= '{1'b0, 1'b1, a, 4'h0, 32'h0000_0000};
    @(posedge ref_clk);
    cfg_req.rd <= 1'b0;
    #1;
    chk(32'(cfg_rsp.valid), 32'h0000_0001);
    chk(cfg_rsp.data, exp);
  endtask : cfg_rd

  // Transaction with expected {down, up, refused, ignored}
  task automatic io(input logic sec, input logic [31:0] a, input logic [3:0] exp);
    u_iowfd_bus_model.issue(sec, a);
    #1;
    chk(32'({down_fwd, up_fwd, pri_isa_refused, sec_ignored}), 32'(exp));
    if (exp[3]) chk(down_addr, a);
    if (exp[2]) chk(up_addr, a);
  endtask : io

  // Reset window
  task automatic t_reset;
    cfg_rd(8'h1C, 32'h0000_0101);
    cfg_rd(8'h30, 32'h0000_0000);
    io(1'b0, 32'h0000_0FFF, 4'h8);
    io(1'b0, 32'h0000_1000, 4'h0);
    io(1'b1, 32'h0000_1000, 4'h4);
    io(1'b1, 32'h0000_0FFF, 4'h0);
  endtask : t_reset

  // Programmed window and field access
  task automatic t_regs;
    cfg_wr(8'h30, 4'hF, 32'h0001_0001);
    cfg_wr(8'h1C, 4'h3, 32'h0000_302F);
    cfg_rd(8'h1C, 32'h0000_3121);
    cfg_rd(8'h30, 32'h0001_0001);
    cfg_rd(8'h04, 32'h0000_0000);
    io(1'b0, 32'h0001_1FFF, 4'h0);
    io(1'b0, 32'h0001_2000, 4'h8);
    io(1'b0, 32'h0001_3FFF, 4'h8);
    io(1'b1, 32'h0001_4000, 4'h4);
    @(posedge ref_clk) isa_enable <= 1'b1;
    io(1'b0, 32'h0001_2300, 4'h8);
  endtask : t_regs

  // Base above limit
  task automatic t_off;
    cfg_wr(8'h30, 4'hF, 32'h0001_0002);
    io(1'b0, 32'h0001_2000, 4'h0);
    io(1'b1, 32'h0001_2000, 4'h4);
  endtask : t_off

  // Legacy filter on window 0000_0000h to 0000_FFFFh
  task automatic t_isa;
    cfg_wr(8'h30, 4'hF, 32'h0000_0000);
    cfg_wr(8'h1C, 4'h3, 32'h0000_F000);
    io(1'b0, 32'h0000_00FF, 4'h8);
    io(1'b0, 32'h0000_0100, 4'h2);
    io(1'b0, 32'h0000_FFFF, 4'h2);
    io(1'b0, 32'h0000_0400, 4'h8);
    io(1'b1, 32'h0000_0300, 4'h4);
    io(1'b1, 32'h0000_0400, 4'h0);
    @(posedge ref_clk) isa_enable <= 1'b0;
    io(1'b0, 32'h0000_0100, 4'h8);
  endtask : t_isa

  // Enable bits cleared
  task automatic t_enables;
    @(posedge ref_clk) io_enable <= 1'b0;
    io(1'b0, 32'h0000_0010, 4'h0);
    @(posedge ref_clk) master_enable <= 1'b0;
    io(1'b1, 32'h0001_0000, 4'h1);
  endtask : t_enables

  // Clock enable low: write and request not taken, outputs held
  task automatic t_freeze;
    @(posedge ref_clk);
    io_enable <= 1'b1;
    master_enable <= 1'b1;
    clk_en <= 1'b0;
    cfg_wr(8'h30, 4'h3, 32'h0000_0005);
    io(1'b0, 32'h0000_0010, 4'h0);
    @(posedge ref_clk) clk_en <= 1'b1;
    cfg_rd(8'h30, 32'h0000_0000);
    io(1'b0, 32'h0000_0010, 4'h8);
  endtask : t_freeze

  // Reset in mid-run brings back the bottom 4 KB window
  task automatic t_rerst;
    cfg_wr(8'h30, 4'hF, 32'h0003_0002);
    @(posedge ref_clk) rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    cfg_rd(8'h1C, 32'h0000_0101);
    cfg_rd(8'h30, 32'h0000_0000);
    io(1'b0, 32'h0000_0FFF, 4'h8);
    io(1'b0, 32'h0000_1000, 4'h0);
  endtask : t_rerst

  // Verdict and end of run
  task automatic finish_test;
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  // Main sequence, enables set before the window is programmed
  initial begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    io_enable <= 1'b1;
    master_enable <= 1'b1;
    t_reset;
    t_regs;
    t_off;
    t_isa;
    t_enables;
    t_freeze;
    t_rerst;
    finish_test;
  end

  // Watchdog
  initial begin
    #20000;
    miscompares++;
    finish_test;
  end
endmodule : iowfd_decoder_tb
